/* aic_top.sv */
// Behaviour
// - one global bit selects fractional or integer results for all channels
// - two-bit channel mode: 11 diff signed, 10 diff unsigned, 01 se signed
// - each channel raises its own request when its conversion completes
// - per-channel requests individually enabled by enable bits
// - one global interrupt flags completed conversions on any channels
// - per-channel global enable: 1 contributes to global interrupt, 0 not
// - setting converter on runs calibration, then hardware sets ready flag
// - per-pin bit: 1 selects analog mode, 0 selects digital mode
// - conversions continue during debug halt, no freeze
module aic_top #(
    parameter int NCH        = 8,
    parameter int NPIN       = 16,
    parameter int NCAL       = 4,
    parameter int RES_W      = 12,
    parameter int CAL_CYCLES = aic_pkg::CAL_CYCLES
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst_b,
    input  wire logic [7:0]              paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [NCH-1:0]          conv_done,
    input  wire logic [NCH*RES_W-1:0]    conv_code,
    output logic      [NCH-1:0]          conv_start,
    output logic      [NCH-1:0]          chan_diff,
    output logic                         conv_enable,
    output logic                         cal_run,
    output logic      [NCAL-1:0][31:0]   converter_cal_register,
    output logic      [NPIN-1:0]         pin_analog_select,
    output logic      [NCH-1:0]          chan_irq,
    output logic                         irq
);

    // read mux pads mode and pin fields to 32 bits: a full word leaves no pad
    if (NCH < 1 || NCH > 15) begin : g_bad_nch
        $error("aic_top: NCH must be 1..15");
    end
    if (NPIN < 1 || NPIN > 31) begin : g_bad_npin
        $error("aic_top: NPIN must be 1..31");
    end
    // four-bit word index limits the calibration block
    if (NCAL < 1 || NCAL > 16) begin : g_bad_ncal
        $error("aic_top: NCAL must be 1..16");
    end
    if (CAL_CYCLES < 1 || CAL_CYCLES >= (1 << aic_pkg::CNT_W)) begin : g_bad_cal
        $error("aic_top: CAL_CYCLES out of range");
    end

    localparam logic [aic_pkg::CNT_W-1:0] CAL_LAST = aic_pkg::CNT_W'(CAL_CYCLES - 1);

    function automatic logic [3:0] word_idx(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] d;
        d = addr - base;
        return d[5:2];
    endfunction

    function automatic logic in_block(input logic [7:0] addr, input logic [7:0] base,
                                      input int n);
        logic [8:0] top;
        top = 9'(base) + 9'(n * 4);
        return (addr >= base) && (9'(addr) < top);
    endfunction

    function automatic logic [31:0] zext_ch(input logic [NCH-1:0] v);
        return {{(32-NCH){1'b0}}, v};
    endfunction

    aic_pkg::aic_ctrl_type            ctrl;
    aic_pkg::aic_ctrl_type            next_ctrl;
    logic [2*NCH-1:0]                 mode;
    logic [2*NCH-1:0]                 next_mode;
    logic [NCH-1:0]                   gien;
    logic [NCH-1:0]                   next_gien;
    logic [NCH-1:0]                   cien;
    logic [NCH-1:0]                   next_cien;
    logic [NCH-1:0]                   istat;
    logic [NCH-1:0]                   next_istat;
    logic [NPIN-1:0]                  next_asel;
    logic [NCAL-1:0][31:0]            next_cal;
    logic [NCH-1:0][31:0]             result;
    logic [NCH-1:0][31:0]             next_result;
    logic [NCH-1:0][31:0]             fmt_data;
    aic_pkg::aic_cal_state_type       cal_state;
    aic_pkg::aic_cal_state_type       next_cal_state;
    logic [aic_pkg::CNT_W-1:0]        cal_cnt;
    logic [aic_pkg::CNT_W-1:0]        next_cal_cnt;
    logic [31:0]                      next_prdata;
    logic                             next_pready;
    logic                             next_pslverr;
    logic [NCH-1:0]                   next_conv_start;
    logic [NCH-1:0]                   next_chan_diff;
    logic                             next_conv_enable;
    logic                             next_cal_run;
    logic [NCH-1:0]                   next_chan_irq;
    logic                             next_irq;
    logic                             wr_en;
    logic                             access;
    logic                             mapped;
    logic [31:0]                      rd_val;
    logic [NCH-1:0]                   clr_mask;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_fmt
            aic_format #(
                .RES_W(RES_W)
            ) u_format (
                .code                    (conv_code[g*RES_W +: RES_W]),
                .channel_input_sign_mode (mode[g*2 +: 2]),
                .fraction_format_sel     (ctrl.fraction_format_sel),
                .data                    (fmt_data[g])
            );
        end
    endgenerate

    always_comb begin
        access = psel && penable && !pready;
        wr_en  = psel && penable && pready && pwrite;
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        if (paddr == aic_pkg::CTRL_OFS) begin
            rd_val[aic_pkg::CTRL_ON_BIT]    = ctrl.converter_on;
            rd_val[aic_pkg::CTRL_FRACTION_FORMAT_SEL_BIT] = ctrl.fraction_format_sel;
        end else if (paddr == aic_pkg::STATUS_OFS) begin
            rd_val[aic_pkg::STAT_RDY_BIT]  = (cal_state == aic_pkg::CAL_READY);
            rd_val[aic_pkg::STAT_BUSY_BIT] = (cal_state == aic_pkg::CAL_RUN);
        end else if (paddr == aic_pkg::MODE_OFS) begin
            rd_val = {{(32-2*NCH){1'b0}}, mode};
        end else if (paddr == aic_pkg::GIEN_OFS) begin
            rd_val = zext_ch(gien);
        end else if (paddr == aic_pkg::CIEN_OFS) begin
            rd_val = zext_ch(cien);
        end else if (paddr == aic_pkg::TRIG_OFS) begin
            rd_val = 32'h0000_0000;
        end else if (paddr == aic_pkg::ASEL_OFS) begin
            rd_val = {{(32-NPIN){1'b0}}, pin_analog_select};
        end else if (paddr == aic_pkg::ISTAT_OFS) begin
            rd_val = zext_ch(istat);
        end else if (paddr == aic_pkg::ICLR_OFS) begin
            rd_val = 32'h0000_0000;
        end else if (in_block(paddr, aic_pkg::CAL_BASE, NCAL)) begin
            rd_val = converter_cal_register[word_idx(paddr, aic_pkg::CAL_BASE)];
        end else if (in_block(paddr, aic_pkg::RES_BASE, NCH)) begin
            rd_val = result[word_idx(paddr, aic_pkg::RES_BASE)];
        end else begin
            mapped = 1'b0;
        end
    end

    always_comb begin
        next_ctrl        = ctrl;
        next_mode        = mode;
        next_gien        = gien;
        next_cien        = cien;
        next_asel        = pin_analog_select;
        next_cal         = converter_cal_register;
        next_result      = result;
        next_conv_start  = '0;
        clr_mask         = '0;
        // one wait state: answer in the cycle after setup+access
        next_pready      = access;
        next_pslverr     = access && !mapped;
        next_prdata      = (access && !pwrite && mapped) ? rd_val : 32'h0000_0000;
        if (wr_en && mapped) begin
            if (paddr == aic_pkg::CTRL_OFS) begin
                next_ctrl.converter_on        = pwdata[aic_pkg::CTRL_ON_BIT];
                next_ctrl.fraction_format_sel = pwdata[aic_pkg::CTRL_FRACTION_FORMAT_SEL_BIT];
            end else if (paddr == aic_pkg::MODE_OFS) begin
                next_mode = pwdata[2*NCH-1:0];
            end else if (paddr == aic_pkg::GIEN_OFS) begin
                next_gien = pwdata[NCH-1:0];
            end else if (paddr == aic_pkg::CIEN_OFS) begin
                next_cien = pwdata[NCH-1:0];
            end else if (paddr == aic_pkg::TRIG_OFS) begin
                if (cal_state == aic_pkg::CAL_READY) begin
                    next_conv_start = pwdata[NCH-1:0];
                end
            end else if (paddr == aic_pkg::ASEL_OFS) begin
                next_asel = pwdata[NPIN-1:0];
            end else if (paddr == aic_pkg::ICLR_OFS) begin
                clr_mask = pwdata[NCH-1:0];
            end else if (in_block(paddr, aic_pkg::CAL_BASE, NCAL)) begin
                next_cal[word_idx(paddr, aic_pkg::CAL_BASE)] = pwdata;
            end
        end
        // no halt input: capture never freezes
        for (int i = 0; i < NCH; i++) begin
            if (conv_done[i]) begin
                next_result[i] = fmt_data[i];
            end
        end
        next_istat       = (istat & ~clr_mask) | conv_done;
        for (int i = 0; i < NCH; i++) begin
            next_chan_diff[i] = next_mode[i*2 + aic_pkg::MODE_DIFF_BIT];
        end
        next_chan_irq    = next_istat & next_cien;
        next_irq         = |(next_istat & next_gien);
    end

    always_comb begin
        next_cal_state = cal_state;
        next_cal_cnt   = cal_cnt;
        case (cal_state)
            aic_pkg::CAL_IDLE: begin
                next_cal_cnt = '0;
                if (ctrl.converter_on) begin
                    next_cal_state = aic_pkg::CAL_RUN;
                end
            end
            aic_pkg::CAL_RUN: begin
                next_cal_cnt = cal_cnt + 1'b1;
                if (!ctrl.converter_on) begin
                    next_cal_state = aic_pkg::CAL_IDLE;
                end else if (cal_cnt == CAL_LAST) begin
                    next_cal_state = aic_pkg::CAL_READY;
                end
            end
            aic_pkg::CAL_READY: begin
                if (!ctrl.converter_on) begin
                    next_cal_state = aic_pkg::CAL_IDLE;
                end
            end
            default: begin
                next_cal_state = aic_pkg::CAL_IDLE;
            end
        endcase
        next_conv_enable = (next_cal_state == aic_pkg::CAL_READY);
        next_cal_run     = (next_cal_state == aic_pkg::CAL_RUN);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctrl                   <= '0;
            mode                   <= '0;
            gien                   <= '0;
            cien                   <= '0;
            istat                  <= '0;
            pin_analog_select      <= '0;
            converter_cal_register <= '0;
            result                 <= '0;
            prdata                 <= aic_pkg::REG_RESET;
            pready                 <= 1'b0;
            pslverr                <= 1'b0;
            conv_start             <= '0;
            chan_diff              <= '0;
            chan_irq               <= '0;
            irq                    <= 1'b0;
        end else begin
            ctrl                   <= next_ctrl;
            mode                   <= next_mode;
            gien                   <= next_gien;
            cien                   <= next_cien;
            istat                  <= next_istat;
            pin_analog_select      <= next_asel;
            converter_cal_register <= next_cal;
            result                 <= next_result;
            prdata                 <= next_prdata;
            pready                 <= next_pready;
            pslverr                <= next_pslverr;
            conv_start             <= next_conv_start;
            chan_diff              <= next_chan_diff;
            chan_irq               <= next_chan_irq;
            irq                    <= next_irq;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cal_state   <= aic_pkg::CAL_IDLE;
            cal_cnt     <= '0;
            conv_enable <= 1'b0;
            cal_run     <= 1'b0;
        end else begin
            cal_state   <= next_cal_state;
            cal_cnt     <= next_cal_cnt;
            conv_enable <= next_conv_enable;
            cal_run     <= next_cal_run;
        end
    end

endmodule

/* aic_pkg.sv */
package aic_pkg;

    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MODE_OFS   = 8'h08;
    localparam logic [7:0] GIEN_OFS   = 8'h0c;
    localparam logic [7:0] CIEN_OFS   = 8'h10;
    localparam logic [7:0] TRIG_OFS   = 8'h14;
    localparam logic [7:0] ASEL_OFS   = 8'h18;
    localparam logic [7:0] ISTAT_OFS  = 8'h1c;
    localparam logic [7:0] ICLR_OFS   = 8'h20;
    localparam logic [7:0] CAL_BASE   = 8'h40;
    localparam logic [7:0] RES_BASE   = 8'h80;

    // field positions
    localparam int CTRL_ON_BIT    = 0;
    localparam int CTRL_FRACTION_FORMAT_SEL_BIT = 1;
    localparam int STAT_RDY_BIT   = 0;
    localparam int STAT_BUSY_BIT  = 1;
    localparam int MODE_W         = 2;
    localparam int MODE_SIGN_BIT  = 0;
    localparam int MODE_DIFF_BIT  = 1;

    // reset values
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CAL_TIME_NS   = 1000;
    localparam int CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 12;

    typedef enum logic [1:0] {
        MODE_SE_UNSIGNED   = 2'b00,
        MODE_SE_SIGNED     = 2'b01,
        MODE_DIFF_UNSIGNED = 2'b10,
        MODE_DIFF_SIGNED   = 2'b11
    } aic_mode_type;

    typedef enum logic [1:0] {
        CAL_IDLE  = 2'b00,
        CAL_RUN   = 2'b01,
        CAL_READY = 2'b10
    } aic_cal_state_type;

    typedef struct packed {
        logic fraction_format_sel;
        logic converter_on;
    } aic_ctrl_type;

endpackage

/* aic_format.sv */
module aic_format #(
    parameter int RES_W = 12
) (
    input  wire logic [RES_W-1:0] code,
    input  wire logic [1:0]       channel_input_sign_mode,
    input  wire logic             fraction_format_sel,
    output logic      [31:0]      data
);

    logic [RES_W-1:0] adj;

    // a one-bit code has no sign bit; a full word leaves no pad
    if (RES_W < 2 || RES_W > 31) begin : g_bad_res_w
        $error("aic_format: RES_W out of range");
    end

    always_comb begin
        if (channel_input_sign_mode[aic_pkg::MODE_SIGN_BIT]) begin
            adj = {~code[RES_W-1], code[RES_W-2:0]};
        end else begin
            adj = code;
        end
        if (fraction_format_sel) begin
            data = {adj, {(32-RES_W){1'b0}}};
        end else if (channel_input_sign_mode[aic_pkg::MODE_SIGN_BIT]) begin
            data = {{(32-RES_W){adj[RES_W-1]}}, adj};
        end else begin
            data = {{(32-RES_W){1'b0}}, adj};
        end
    end

endmodule

/* aic_checker.sv */
module aic_checker #(
    parameter int NCH        = 8,
    parameter int CAL_CYCLES = 3
) (
    input wire logic           core_clk,
    input wire logic           rst_b,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    input wire logic [NCH-1:0] conv_done,
    input wire logic [NCH-1:0] conv_start,
    input wire logic           conv_enable,
    input wire logic           cal_run,
    input wire logic [NCH-1:0] chan_irq,
    input wire logic           irq
);
    logic [15:0] run_cnt;
    logic [15:0] next_run_cnt;
    logic        wr_done;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    assign wr_done = psel && penable && pready && pwrite;

    // cycles spent calibrating, cleared when idle
    always_comb begin
        next_run_cnt = cal_run ? run_cnt + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge core_clk) begin
        run_cnt <= rst_b ? next_run_cnt : 16'h0000;
    end

    AST_ACCESS_WAIT:
        assert property (psel && penable && !pready |=> pready) else $error("no pready");
    AST_READY_PULSE:
        assert property (pready |=> !pready) else $error("pready too long");
    AST_ERR_ZERO:
        assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad slverr");
    AST_IDLE_DATA:
        assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    AST_CAL_LEN:
        assert property ($rose(conv_enable) |-> run_cnt == CAL_CYCLES) else $error("cal length");
    AST_NO_OVERLAP:
        assert property (cal_run |-> !conv_enable) else $error("ready while calibrating");
    AST_START_READY:
        assert property (|conv_start |-> conv_enable) else $error("start before ready");
    AST_START_PULSE:
        assert property (|conv_start |=> !(|(conv_start & $past(conv_start))))
            else $error("start not a pulse");
    AST_CHAN_CAUSE:
        assert property (|(chan_irq & ~$past(chan_irq)) |->
            $past(|conv_done) || $past(wr_done) || $past(wr_done, 2)) else $error("chan irq");
    AST_IRQ_CAUSE:
        assert property ($rose(irq) |->
            $past(|conv_done) || $past(wr_done) || $past(wr_done, 2)) else $error("global irq");
    AST_OFF_AFTER_RESET:
        assert property ($rose(rst_b) |-> !conv_enable && !irq) else $error("not idle");
endmodule

bind aic_top aic_checker #(.NCH(NCH), .CAL_CYCLES(CAL_CYCLES)) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
    .conv_start(conv_start), .conv_enable(conv_enable), .cal_run(cal_run),
    .chan_irq(chan_irq), .irq(irq)
);

/* adc_format_irq_calibration_bench.sv */
module adc_format_irq_calibration_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NCH = 8;
    logic            core_clk;
    logic            rst_b;
    logic [7:0]      paddr;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [31:0]     pwdata;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic [7:0]      conv_done;
    logic [95:0]     conv_code;
    logic [7:0]      conv_start;
    logic [7:0]      chan_diff;
    logic            conv_enable;
    logic            cal_run;
    logic [3:0][31:0] cal_regs;
    logic [15:0]     pin_sel;
    logic [7:0]      chan_irq;
    logic            irq;
    int              n_mismatch;
    int              comparisons;
    integer          seed;
    int              k;
    logic [31:0]     rd;
    logic            err;
    logic [31:0]     r;
    logic [95:0]     code;
    logic [7:0]      dx;
    logic [31:0]     m_res [NCH];
    logic [7:0]      m_istat;
    logic [7:0]      m_cien;
    logic [7:0]      m_gien;
    logic [15:0]     m_mode;

    aic_top #(.CAL_CYCLES(8)) dut (
        .core_clk(core_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .conv_code(conv_code),
        .conv_start(conv_start), .chan_diff(chan_diff), .conv_enable(conv_enable),
        .cal_run(cal_run), .converter_cal_register(cal_regs),
        .pin_analog_select(pin_sel), .chan_irq(chan_irq), .irq(irq)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one idle cycle before each setup keeps every signal to one assignment per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (t = 0; t < 20; t++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (t == 20) begin
            n_mismatch++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    function automatic logic [31:0] fmt(input logic [11:0] c, input logic [1:0] md,
                                        input logic fr);
        logic [11:0] v;
        v = md[0] ? c ^ 12'h800 : c;
        if (fr) return {v, 20'h0};
        return md[0] ? {{20{v[11]}}, v} : {20'h0, v};
    endfunction

    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        summarize();
    end

    initial begin
        seed = 32'hb48a;
        {rst_b, paddr, psel, penable, pwrite, pwdata, conv_done, conv_code} = '0;
        m_istat = 8'h00;
        for (int i = 0; i < NCH; i++) m_res[i] = 32'h0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        rdc("status", aic_pkg::STATUS_OFS, 32'h0);
        apb(1'b0, 8'hfc, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, aic_pkg::TRIG_OFS, 32'hff);
        chk("early start", 32'h0, {24'h0, conv_start});
        r = $random(seed);
        apb(1'b1, aic_pkg::ASEL_OFS, r);
        chk("analog sel", {16'h0, r[15:0]}, {16'h0, pin_sel});
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            apb(1'b1, aic_pkg::CAL_BASE + 8'(4 * i), r);
            chk("cal word", r, cal_regs[i]);
        end
        // calibration: busy first, ready only later
        apb(1'b1, aic_pkg::CTRL_OFS, 32'h1);
        rdc("calibrating", aic_pkg::STATUS_OFS, 32'h2);
        chk("cal run", 32'h1, {31'h0, cal_run});
        for (k = 0; k < 40 && rd[0] !== 1'b1; k++) apb(1'b0, aic_pkg::STATUS_OFS, 32'h0);
        chk("cal ready", 32'h1, rd);
        if (rd[0] !== 1'b1) summarize();
        chk("conv enable", 32'h1, {31'h0, conv_enable});
        for (int rnd = 0; rnd < 4; rnd++) begin
            for (int i = 0; i < NCH; i++) begin
                m_mode[2*i +: 2] = 2'(i + rnd);
                dx[i] = m_mode[2*i+1];
            end
            m_cien = $random(seed);
            m_gien = $random(seed);
            apb(1'b1, aic_pkg::CTRL_OFS, {30'h0, rnd[0], 1'b1});
            apb(1'b1, aic_pkg::MODE_OFS, {16'h0, m_mode});
            apb(1'b1, aic_pkg::CIEN_OFS, {24'h0, m_cien});
            apb(1'b1, aic_pkg::GIEN_OFS, {24'h0, m_gien});
            chk("diff", {24'h0, dx}, {24'h0, chan_diff});
            r = $random(seed);
            code = {$random(seed), $random(seed), $random(seed)};
            @(posedge core_clk);
            conv_done <= r[7:0];
            conv_code <= code;
            @(posedge core_clk);
            conv_done <= 8'h00;
            for (int i = 0; i < NCH; i++)
                if (r[i]) m_res[i] = fmt(code[12*i +: 12], m_mode[2*i +: 2], rnd[0]);
            m_istat = m_istat | r[7:0];
            @(posedge core_clk);
            #1;
            chk("chan irq", {24'h0, m_istat & m_cien}, {24'h0, chan_irq});
            chk("irq", {31'h0, |(m_istat & m_gien)}, {31'h0, irq});
            for (int i = 0; i < NCH; i++)
                rdc("result", aic_pkg::RES_BASE + 8'(4 * i), m_res[i]);
            rdc("istat", aic_pkg::ISTAT_OFS, {24'h0, m_istat});
            r = $random(seed);
            apb(1'b1, aic_pkg::ICLR_OFS, r);
            m_istat = m_istat & ~r[7:0];
            repeat (2) @(posedge core_clk);
            #1;
            chk("irq clr", {31'h0, |(m_istat & m_gien)}, {31'h0, irq});
            chk("chan clr", {24'h0, m_istat & m_cien}, {24'h0, chan_irq});
        end
        r = $random(seed);
        apb(1'b1, aic_pkg::TRIG_OFS, r);
        chk("start", {24'h0, r[7:0]}, {24'h0, conv_start});
        apb(1'b1, aic_pkg::CTRL_OFS, 32'h0);
        rdc("off", aic_pkg::STATUS_OFS, 32'h0);
        chk("off enable", 32'h0, {31'h0, conv_enable});
        summarize();
    end
endmodule
